// ===== tmon_pkg.sv
// package of constants and types for the temperature alarm and alert logic
// ----------------------------------------------------------------------------
// Notes on behaviour
// - alert low on limit violation or open sensor
// - alert pin only pulls low or releases
// - host answers low alert with response-address read
// - device returns own address, lsb set
// - lowest address wins concurrent alert responses
// - release alert after response if condition cleared
// - host repeats reads while alert line low
// - config bit 6 halts converter, aborts conversion
// - registers stay accessible during standby
// - one-shot write converts both channels once
// - new limits in standby may raise alert
// - alert maskable, overtemp failsafe never masked
// - temperature at or below low limit alerts
// - temperature above high limit alerts
// - overtemp low when channel exceeds its limit
// - software keeps overtemp limit above high limit
// - shared hysteresis, resets to ten degrees
// - hysteresis held as unsigned degree count
// - open sensor sampled at conversion start, status bit2
// - shorted sensor code minus 128 alerts unless alert masked
// ----------------------------------------------------------------------------
package tmon_pkg;
  // device register pointers
  localparam logic [7:0] REG_LOCAL_VALUE   = 8'h00;
  localparam logic [7:0] REG_REMOTE_VALUE  = 8'h01;
  localparam logic [7:0] REG_STATUS        = 8'h02;
  localparam logic [7:0] REG_CONFIG_RD     = 8'h03;
  localparam logic [7:0] REG_CONFIG_WR     = 8'h09;
  localparam logic [7:0] REG_LOCAL_HIGH_WR = 8'h0B;
  localparam logic [7:0] REG_LOCAL_LOW_WR  = 8'h0C;
  localparam logic [7:0] REG_REM_HIGH_WR   = 8'h0D;
  localparam logic [7:0] REG_REM_LOW_WR    = 8'h0E;
  localparam logic [7:0] REG_ONE_SHOT      = 8'h0F;
  localparam logic [7:0] REG_REM_OVT       = 8'h19;
  localparam logic [7:0] REG_LOCAL_OVT     = 8'h20;
  localparam logic [7:0] REG_OVT_HYST      = 8'h21;
  // reset values
  localparam logic [7:0] RST_HIGH_LIMIT    = 8'h55;
  localparam logic [7:0] RST_LOW_LIMIT     = 8'h00;
  localparam logic [7:0] RST_OVT_LIMIT     = 8'h55;
  localparam logic [7:0] RST_HYST          = 8'h0A;
  // field positions
  localparam int CFG_MASK_BIT    = 7;
  localparam int CFG_STANDBY_BIT = 6;
  localparam int ST_OPEN_BIT     = 2;
  localparam logic [7:0] SHORT_CODE = 8'h80;
  // link framing
  localparam logic [6:0] ARA_ADDR  = 7'h0C;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_ARA    = 2'h3;
  // link serial frame: 2 op bits, 8 pointer bits, 8 data bits
  localparam int FRAME_BITS = 18;
  // link clock divider: 40 MHz / 8 gives 5 MHz, a 200 ns period
  localparam int CLK_MHZ     = 40;
  localparam int LINK_NS     = 200;
  localparam int LINK_HALF   = (CLK_MHZ * LINK_NS) / 2000;
  // conversion length in system clocks
  localparam int CONV_NS     = 1000;
  localparam int CONV_CYCLES = (CONV_NS * CLK_MHZ) / 1000;
  // APB register offsets of the host controller
  localparam logic [7:0] APB_CMD    = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_RDATA  = 8'h08;
  localparam int CMD_OP_LSB  = 16;
  localparam int CMD_PTR_LSB = 8;
  typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_SHIFT = 2'b01, HS_TURN = 2'b11, HS_READ = 2'b10} tmon_hstate_type;
endpackage

// ===== tmon_link_if.sv
// interface joining the host controller and the monitor over the serial link
`timescale 1ns/1ps
interface tmon_link_if;
  logic linkClk;
  logic hostDataOut;
  logic hostDataOe_n;
  logic devDataOut;
  logic devDataOe_n;
  logic alertOut;
  logic alertOe_n;
  wire  dataLine  = ~(~hostDataOe_n & ~hostDataOut) & ~(~devDataOe_n & ~devDataOut);
  wire  alertLine = ~(~alertOe_n & ~alertOut);
  modport host (output linkClk, output hostDataOut, output hostDataOe_n, input dataLine, input alertLine);
  modport dev  (input linkClk, output devDataOut, output devDataOe_n, output alertOut, output alertOe_n,
                input dataLine);
endinterface

// ===== tmon_sync.sv
// two-flop synchroniser with edge outputs for link signals
`timescale 1ns/1ps
module tmon_sync #(
  parameter logic IDLE = 1'b1  // level the pin rests at, so leaving reset shows no false edge
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= IDLE;
      sync_q <= IDLE;
      prev_q <= IDLE;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
  assign fall  = ~sync_q & prev_q;
endmodule // tmon_sync

// ===== tmon_host.sv
// host controller: APB command registers, drives link clock, frames link transfers
`timescale 1ns/1ps
module tmon_host
  import tmon_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  psel,
  input  wire logic  penable,
  input  wire logic  pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  tmon_link_if.host   link
);
  import tmon_pkg::*;
  tmon_hstate_type state_q;
  logic [17:0] shift_q;
  logic [4:0]  bitCnt_q;
  logic [7:0]  rdata_q;
  logic [3:0]  div_q;
  logic        clk_q, oe_n_q, out_q, pready_q, done_q;
  logic [31:0] prdata_q;
  logic        alertSync, dataSync;
  tmon_sync uAlert (.clk(clk), .rst(rst), .din(link.alertLine), .level(alertSync), .rise(), .fall());
  tmon_sync uData  (.clk(clk), .rst(rst), .din(link.dataLine), .level(dataSync), .rise(), .fall());
  wire access  = psel & penable & ~pready_q;
  // a command lands at the edge where the master sees pready, not earlier
  wire cmdWr   = psel & penable & pready_q & pwrite & (paddr == APB_CMD) & (state_q == HS_IDLE);
  wire halfEnd = (div_q == 4'(LINK_HALF - 1));
  wire fallTick = halfEnd & clk_q;
  wire riseTick = halfEnd & ~clk_q;
  wire lastFall = fallTick & (state_q == HS_SHIFT) & (bitCnt_q == 5'(FRAME_BITS));
  wire isRead  = (shift_q[17:16] != OP_WRITE);
  wire [31:0] rdMux = (paddr == APB_STATUS) ? {29'h0, ~alertSync, done_q, state_q != HS_IDLE} :
                      (paddr == APB_RDATA)  ? {24'h0, rdata_q} : 32'h0;
  wire mapped = (paddr == APB_CMD) | (paddr == APB_STATUS) | (paddr == APB_RDATA);
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr  <= 1'b0;
    end else begin
      pready_q <= access;
      prdata_q <= access ? rdMux : prdata_q;
      pslverr  <= access & ~mapped;
    end
  end
  // link clock from a divider, stopped high between frames
  always_ff @(posedge clk) begin
    if (rst || state_q == HS_IDLE) begin
      div_q <= 4'h0;
      clk_q <= 1'b1;
    end else begin
      div_q <= halfEnd ? 4'h0 : div_q + 4'h1;
      // no fall after a write frame: a stray low pulse would clock one bit too many
      clk_q <= (halfEnd && !lastFall) ? ~clk_q : clk_q;
    end
  end
  // software sets op in cmd; ARA reads answer with the responder address
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q  <= HS_IDLE;
      shift_q  <= 18'h0;
      bitCnt_q <= 5'h0;
      rdata_q  <= 8'h0;
      oe_n_q   <= 1'b1;
      out_q    <= 1'b1;
      done_q   <= 1'b0;
    end else begin
      case (state_q)
        HS_IDLE: begin
          oe_n_q <= 1'b1;
          if (cmdWr) begin
            shift_q  <= {pwdata[CMD_OP_LSB +: 2], pwdata[CMD_PTR_LSB +: 8], pwdata[7:0]};
            bitCnt_q <= 5'h0;
            done_q   <= 1'b0;
            state_q  <= HS_SHIFT;
          end
        end
        HS_SHIFT: if (fallTick) begin
          oe_n_q  <= 1'b0;
          out_q   <= (bitCnt_q < 5'(FRAME_BITS)) ? shift_q[17 - bitCnt_q] : 1'b1;
          if (bitCnt_q == 5'd10 && isRead) begin
            oe_n_q  <= 1'b1;  // hand the line over before the device drives
            state_q <= HS_TURN;
          end else if (bitCnt_q == 5'(FRAME_BITS)) begin
            oe_n_q  <= 1'b1;
            done_q  <= 1'b1;
            state_q <= HS_IDLE;
          end
          bitCnt_q <= bitCnt_q + 5'h1;
        end
        HS_TURN: if (fallTick) begin
          oe_n_q   <= 1'b1;
          bitCnt_q <= 5'h0;
          state_q  <= HS_READ;
        end
        HS_READ: if (riseTick) begin
          rdata_q  <= {rdata_q[6:0], dataSync};
          bitCnt_q <= bitCnt_q + 5'h1;
          if (bitCnt_q == 5'd7) begin
            done_q  <= 1'b1;
            state_q <= HS_IDLE;
          end
        end
        default: state_q <= HS_IDLE;
      endcase
    end
  end
  assign link.linkClk      = clk_q;
  assign link.hostDataOut  = out_q;
  assign link.hostDataOe_n = oe_n_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
endmodule // tmon_host

// ===== tmon_device.sv
// monitor end: registers, limit comparison, alert and overtemp failsafe
`timescale 1ns/1ps
module tmon_device
  import tmon_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // arbitrary bus address
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] localSample,
  input  wire logic [7:0] remoteSample,
  input  wire logic       openDetect,
  output logic            overtemp_failsafe_out_n,
  output logic            converting,
  tmon_link_if.dev        link
);
  import tmon_pkg::*;
  logic [7:0] localVal_q, remoteVal_q, config_q, locHigh_q, locLow_q, remHigh_q, remLow_q;
  logic [7:0] locOvt_q, remOvt_q, overtemp_hysteresis_q;
  logic       openFlag_q, alert_q, locOvt_hold_q, remOvt_hold_q, ovtN_q, conv_q, oneShot_q;
  logic       singleShot_q, araPend_q;
  logic [15:0] convCnt_q;
  logic [17:0] rx_q;
  logic [4:0]  bitCnt_q;
  logic [7:0]  tx_q;
  logic        txActive_q, devOe_n_q, devOut_q, araAck_q;
  logic        lclk, lclkRise, lclkFall, dline, openSync;
  tmon_sync uClk  (.clk(clk), .rst(rst), .din(link.linkClk), .level(lclk), .rise(lclkRise), .fall(lclkFall));
  tmon_sync uDat  (.clk(clk), .rst(rst), .din(link.dataLine), .level(dline), .rise(), .fall());
  tmon_sync #(.IDLE(1'b0)) uOpen (.clk(clk), .rst(rst), .din(openDetect), .level(openSync), .rise(), .fall());
  // ----------------------------------------------------------------------------
  // link receive and decode; registers stay reachable in standby
  // ----------------------------------------------------------------------------
  wire [17:0] rxNext  = {rx_q[16:0], dline};
  wire        frameEnd = lclkRise & ~txActive_q & (bitCnt_q == 5'(FRAME_BITS - 1));
  wire        hdrEnd   = lclkRise & ~txActive_q & (bitCnt_q == 5'd9) & (rxNext[9:8] != OP_WRITE);
  wire [1:0]  op       = rxNext[9:8];
  wire [7:0]  ptr      = rxNext[7:0];
  wire        wrStrobe = frameEnd & (rxNext[17:16] == OP_WRITE);
  wire [7:0]  wrData   = rxNext[7:0];
  wire [7:0]  wrPtr    = rxNext[15:8];
  wire        standby  = config_q[CFG_STANDBY_BIT];
  // ARA answered only while alert asserted; own address, lsb one
  wire        araHit   = hdrEnd & (op == OP_ARA) & alert_q;
  wire        rdHit    = hdrEnd & (op == OP_READ);
  function automatic logic [7:0] rd_mux(input logic [7:0] p);
    case (p)
      REG_LOCAL_VALUE:  rd_mux = localVal_q;
      REG_REMOTE_VALUE: rd_mux = remoteVal_q;
      REG_STATUS:       rd_mux = {5'h0, openFlag_q, 2'h0};
      REG_CONFIG_RD:    rd_mux = config_q;
      REG_REM_OVT:      rd_mux = remOvt_q;
      REG_LOCAL_OVT:    rd_mux = locOvt_q;
      REG_OVT_HYST:     rd_mux = overtemp_hysteresis_q;
      default:          rd_mux = 8'h00;
    endcase
  endfunction
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_q <= 18'h0;
      bitCnt_q <= 5'h0;
      txActive_q <= 1'b0;
      tx_q <= 8'h0;
      devOe_n_q <= 1'b1;
      devOut_q <= 1'b1;
      araAck_q <= 1'b0;
      araPend_q <= 1'b0;
    end else begin
      araAck_q <= 1'b0;
      if (!txActive_q && lclkRise) begin
        rx_q <= rxNext;
        bitCnt_q <= (frameEnd || hdrEnd) ? 5'h0 : bitCnt_q + 5'h1;
      end
      if (hdrEnd) begin
        txActive_q <= 1'b1;
        // an unanswered read still owns the next nine falls, so the receiver stays framed
        tx_q <= araHit ? {DEV_ADDR, 1'b1} : rdHit ? rd_mux(ptr) : 8'hFF;
        araPend_q <= araHit;
      end else if (txActive_q && lclkFall && bitCnt_q != 5'd9) begin
        devOe_n_q <= tx_q[7];  // only pull low, arbitration by wired line
        devOut_q <= 1'b0;
        tx_q <= {tx_q[6:0], 1'b1};
        bitCnt_q <= bitCnt_q + 5'h1;
      end else if (txActive_q && lclkRise && bitCnt_q == 5'd9) begin
        // the host takes the last bit on this rise; only now is the address delivered
        txActive_q <= 1'b0;
        bitCnt_q <= 5'h0;
        araAck_q <= araPend_q;
        araPend_q <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      config_q <= 8'h00;
      locHigh_q <= RST_HIGH_LIMIT;
      remHigh_q <= RST_HIGH_LIMIT;
      locLow_q <= RST_LOW_LIMIT;
      remLow_q <= RST_LOW_LIMIT;
      locOvt_q <= RST_OVT_LIMIT;
      remOvt_q <= RST_OVT_LIMIT;
      overtemp_hysteresis_q <= RST_HYST;
      oneShot_q <= 1'b0;
    end else begin
      oneShot_q <= wrStrobe & (wrPtr == REG_ONE_SHOT);  // any data value
      if (wrStrobe) begin
        case (wrPtr)
          REG_CONFIG_WR:     config_q <= wrData;
          REG_LOCAL_HIGH_WR: locHigh_q <= wrData;  // limits writable in standby
          REG_LOCAL_LOW_WR:  locLow_q <= wrData;
          REG_REM_HIGH_WR:   remHigh_q <= wrData;
          REG_REM_LOW_WR:    remLow_q <= wrData;
          REG_LOCAL_OVT:     locOvt_q <= wrData;
          REG_REM_OVT:       remOvt_q <= wrData;
          REG_OVT_HYST:      overtemp_hysteresis_q <= wrData;  // unsigned degrees
          default:           config_q <= config_q;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------------------
  wire convStart = ~conv_q & (~standby | oneShot_q);
  // a one-shot run must outlive its one-cycle trigger, so it is remembered
  wire convAbort = conv_q & standby & ~singleShot_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_q <= 1'b0;
      convCnt_q <= 16'h0;
      localVal_q <= 8'h00;
      remoteVal_q <= 8'h00;
      openFlag_q <= 1'b0;
      singleShot_q <= 1'b0;
    end else if (convStart) begin
      conv_q <= 1'b1;
      convCnt_q <= 16'h0;
      singleShot_q <= standby;
      openFlag_q <= openSync;  // sampled at conversion start
    end else if (convAbort) begin
      conv_q <= 1'b0;  // abort, value kept
      convCnt_q <= 16'h0;
    end else if (conv_q) begin
      convCnt_q <= convCnt_q + 16'h1;
      if (convCnt_q == 16'(CONV_CYCLES - 1)) begin
        conv_q <= 1'b0;
        singleShot_q <= 1'b0;
        localVal_q <= localSample;
        remoteVal_q <= remoteSample;  // short gives the minus-128 code
      end
    end
  end
  // ----------------------------------------------------------------------------
  // alarm comparisons, signed two's complement
  // ----------------------------------------------------------------------------
  wire locLowHit  = $signed(localVal_q)  <= $signed(locLow_q);
  wire remLowHit  = $signed(remoteVal_q) <= $signed(remLow_q);
  wire locHighHit = $signed(localVal_q)  >  $signed(locHigh_q);
  wire remHighHit = $signed(remoteVal_q) >  $signed(remHigh_q);
  wire alertCond  = (locLowHit | remLowHit | locHighHit | remHighHit | openFlag_q) & ~config_q[CFG_MASK_BIT];
  // ten bits: the lowest limit minus the largest hysteresis must not wrap
  wire [9:0] locRel = {{2{locOvt_q[7]}}, locOvt_q} - {2'b00, overtemp_hysteresis_q};
  wire [9:0] remRel = {{2{remOvt_q[7]}}, remOvt_q} - {2'b00, overtemp_hysteresis_q};
  wire locOver = $signed(localVal_q) > $signed(locOvt_q);
  wire remOver = $signed(remoteVal_q) > $signed(remOvt_q);
  wire locBelow = $signed({{2{localVal_q[7]}}, localVal_q}) <= $signed(locRel);
  wire remBelow = $signed({{2{remoteVal_q[7]}}, remoteVal_q}) <= $signed(remRel);
  always_ff @(posedge clk) begin
    if (rst) begin
      alert_q <= 1'b0;
      locOvt_hold_q <= 1'b0;
      remOvt_hold_q <= 1'b0;
      ovtN_q <= 1'b1;
    end else begin
      // latched; freed only by an answered ARA once the cause is gone
      alert_q <= alertCond | (alert_q & ~araAck_q);
      locOvt_hold_q <= locOver | (locOvt_hold_q & ~locBelow);
      remOvt_hold_q <= remOver | (remOvt_hold_q & ~remBelow);
      ovtN_q <= ~(locOvt_hold_q | remOvt_hold_q);  // not maskable
    end
  end
  assign overtemp_failsafe_out_n = ovtN_q;
  assign converting = conv_q;
  assign link.alertOut   = 1'b0;
  assign link.alertOe_n  = ~alert_q;
  assign link.devDataOut  = devOut_q;
  assign link.devDataOe_n = devOe_n_q;
endmodule // tmon_device

// ===== tmon_sva.sv
// checker of the link signals between host controller and monitor
`timescale 1ns/1ps
module tmon_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic hostDataOe_n,
  input wire logic devDataOut,
  input wire logic devDataOe_n,
  input wire logic alertOut,
  input wire logic alertOe_n
);
  // --------------------------------------------------------------------------
  // helper counters
  // --------------------------------------------------------------------------
  logic [7:0] sinceDev_q;
  logic [4:0] highCnt_q;
  always_ff @(posedge clk) begin
    if (rst || !devDataOe_n) sinceDev_q <= 8'h00;
    else if (sinceDev_q != 8'hFF) sinceDev_q <= sinceDev_q + 8'h01;
  end
  // saturating, so a long idle spell never wraps back to zero
  always_ff @(posedge clk) begin
    if (rst || !linkClk) highCnt_q <= 5'h00;
    else if (highCnt_q != 5'h1F) highCnt_q <= highCnt_q + 5'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // --------------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------------
  sequence s_low_half;
    (!linkClk) [*4] ##1 linkClk;
  endsequence
  property p_alert_low_only; !alertOe_n |-> !alertOut; endproperty
  property p_data_low_only; !devDataOe_n |-> !devDataOut; endproperty
  property p_no_contend; !devDataOe_n |-> hostDataOe_n; endproperty
  property p_release_after_answer; $rose(alertOe_n) |-> sinceDev_q < 8'd120; endproperty
  property p_link_low; $fell(linkClk) |-> s_low_half; endproperty
  property p_link_high; $rose(linkClk) |-> linkClk [*4]; endproperty
  property p_reset_idle;
    @(posedge clk) disable iff (1'b0) $fell(rst) |-> alertOe_n && linkClk && devDataOe_n;
  endproperty
  property p_quiet_idle; highCnt_q == 5'd16 |-> devDataOe_n; endproperty
  a_alert_low_only: assert property (p_alert_low_only) else $error("alert driven high");
  a_data_low_only: assert property (p_data_low_only) else $error("data driven high");
  a_no_contend: assert property (p_no_contend) else $error("both ends drive data");
  a_release_after_answer: assert property (p_release_after_answer) else $error("alert freed unasked");
  a_link_low: assert property (p_link_low) else $error("link low half wrong");
  a_link_high: assert property (p_link_high) else $error("link high half short");
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
  a_quiet_idle: assert property (p_quiet_idle) else $error("data held when idle");
endmodule // tmon_sva

// ===== tb_top.sv
// testbench joining host controller and monitor across the link
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h expected %h", $time, a, b); end end
module tb_top;
  import tmon_pkg::*;
  localparam logic [6:0] DADDR = 7'h2A; // arbitrary bus address
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, lastErr;
  logic        openDetect, failN, conv;
  logic [7:0]  paddr, locS, remS, q;
  logic [31:0] pwdata, prdata;
  int          miscompares, check_count;
  tmon_link_if lk ();
  tmon_host i_tmon_host (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lk));
  tmon_device #(.DEV_ADDR(DADDR)) i_tmon_device (.clk(clk), .rst(rst), .localSample(locS),
    .remoteSample(remS), .openDetect(openDetect), .overtemp_failsafe_out_n(failN),
    .converting(conv), .link(lk));
  tmon_sva i_tmon_sva (.clk(clk), .rst(rst), .linkClk(lk.linkClk), .hostDataOe_n(lk.hostDataOe_n),
    .devDataOut(lk.devDataOut), .devDataOe_n(lk.devDataOe_n), .alertOut(lk.alertOut),
    .alertOe_n(lk.alertOe_n));
  // --------------------------------------------------------------------------
  // bus tasks
  // --------------------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // busy is polled, so the bench never assumes a frame length
  task automatic op(input logic [1:0] o, input logic [7:0] p, input logic [7:0] d, output logic [7:0] v);
    logic [31:0] r;
    apb(1'b1, APB_CMD, {14'h0000, o, p, d}, r);
    do apb(1'b0, APB_STATUS, 32'h0, r); while (r[0] !== 1'b0);
    apb(1'b0, APB_RDATA, 32'h0, r);
    v = r[7:0];
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] v;
    op(OP_WRITE, p, d, v);
  endtask
  task automatic rd(input logic [7:0] p);
    op(OP_READ, p, 8'h00, q);
  endtask
  task automatic ara();
    op(OP_ARA, {1'b0, ARA_ADDR}, 8'h00, q);
  endtask
  task automatic st(input logic [7:0] l, input logic [7:0] r);
    @(posedge clk);
    locS <= l;
    remS <= r;
    repeat (4 * CONV_CYCLES) @(posedge clk);
  endtask
  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] r;
    rd(REG_OVT_HYST); `CHK(q, 8'h0A)
    wr(REG_OVT_HYST, 8'h05); rd(REG_OVT_HYST); `CHK(q, 8'h05)
    wr(REG_OVT_HYST, RST_HYST);
    apb(1'b0, 8'h3C, 32'h0, r); `CHK(lastErr, 1'b1)
  endtask
  task automatic t_limits();
    // values read zero before the first conversion, so the power-up alert is answered first
    st(8'h19, 8'h19); ara(); `CHK(q, {DADDR, 1'b1})
    ara(); `CHK(q, 8'hFF)
    `CHK(lk.alertLine, 1'b1)
    wr(REG_LOCAL_LOW_WR, 8'h19); `CHK(lk.alertLine, 1'b0)
    ara(); `CHK(q, {DADDR, 1'b1})
    `CHK(lk.alertLine, 1'b0)
    wr(REG_LOCAL_LOW_WR, 8'h00); ara(); `CHK(lk.alertLine, 1'b1)
    st(8'h55, 8'h19); `CHK(lk.alertLine, 1'b1)
    st(8'h19, 8'h56); `CHK(lk.alertLine, 1'b0)
    st(8'h19, 8'h19); ara(); `CHK(lk.alertLine, 1'b1)
  endtask
  task automatic t_ovt();
    st(8'h19, 8'h55); `CHK(failN, 1'b1)
    st(8'h19, 8'h60); `CHK(failN, 1'b0)
    st(8'h19, 8'h4C); `CHK(failN, 1'b0)
    st(8'h19, 8'h4B); `CHK(failN, 1'b1)
    ara(); `CHK(lk.alertLine, 1'b1)
    wr(REG_CONFIG_WR, 8'h80); st(8'h60, 8'h19);
    `CHK(lk.alertLine, 1'b1)
    `CHK(failN, 1'b0)
    st(8'h19, 8'h19); wr(REG_CONFIG_WR, 8'h00); ara(); `CHK(lk.alertLine, 1'b1)
  endtask
  task automatic t_faults();
    st(8'h19, SHORT_CODE); wr(REG_REM_LOW_WR, SHORT_CODE); `CHK(lk.alertLine, 1'b0)
    wr(REG_REM_LOW_WR, 8'h00); st(8'h19, 8'h19); ara();
    @(posedge clk); openDetect <= 1'b1;
    st(8'h19, 8'h19); rd(REG_STATUS); `CHK(q[ST_OPEN_BIT], 1'b1)
    `CHK(lk.alertLine, 1'b0)
    @(posedge clk); openDetect <= 1'b0;
    st(8'h19, 8'h19); ara(); `CHK(lk.alertLine, 1'b1)
  endtask
  // a late conversion would overwrite the stored value, so staleness proves the halt
  task automatic t_standby();
    wr(REG_CONFIG_WR, 8'h40); st(8'h30, 8'h30);
    `CHK(conv, 1'b0)
    rd(REG_LOCAL_VALUE); `CHK(q, 8'h19)
    wr(REG_LOCAL_LOW_WR, 8'h19); `CHK(lk.alertLine, 1'b0)
    wr(REG_LOCAL_LOW_WR, 8'h00); ara(); `CHK(lk.alertLine, 1'b1)
    wr(REG_ONE_SHOT, 8'h5A); st(8'h30, 8'h30);
    rd(REG_LOCAL_VALUE); `CHK(q, 8'h30)
    rd(REG_REMOTE_VALUE); `CHK(q, 8'h30)
    st(8'h19, 8'h19); rd(REG_LOCAL_VALUE); `CHK(q, 8'h30)
    wr(REG_CONFIG_WR, 8'h00); st(8'h19, 8'h19);
  endtask
  // --------------------------------------------------------------------------
  // run control
  // --------------------------------------------------------------------------
  task report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    locS = 8'h19; remS = 8'h19; openDetect = 1'b0; miscompares = 0; check_count = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_limits();
    t_ovt();
    t_faults();
    t_standby();
    report_and_stop();
  end
endmodule // tb_top
